// [rtl/ufmt_regs.vh]
// Register offsets, field positions, reset values and FIFO geometry for the
// UART trigger and line format block. Definitions only; no logic.
`ifndef UFMT_REGS_VH
`define UFMT_REGS_VH

// Register offsets on the plain register port
`define UFMT_OFS_DATA      3'h0
`define UFMT_OFS_IEN       3'h1
`define UFMT_OFS_FIFO      3'h2
`define UFMT_OFS_LINE      3'h3
`define UFMT_OFS_STATUS    3'h4
`define UFMT_OFS_MASK      3'h5
`define UFMT_OFS_EFR       3'h2

// Reset values
`define UFMT_FIFO_RST      8'h00
`define UFMT_LINE_RST      8'h00

// FIFO control fields
`define UFMT_FC_EN         0
`define UFMT_FC_RXCLR      1
`define UFMT_FC_TXCLR      2
`define UFMT_FC_TXT_LO     4
`define UFMT_FC_TXT_HI     5
`define UFMT_FC_RXT_LO     6
`define UFMT_FC_RXT_HI     7

// Line format fields
`define UFMT_LC_STOP       2
`define UFMT_LC_PEN        3
`define UFMT_LC_EVEN       4
`define UFMT_LC_STICK      5
`define UFMT_LC_BRK        6
`define UFMT_LC_DLAB       7

// Enhanced feature unlock bit
`define UFMT_EF_UNLOCK     4

// Status bits
`define UFMT_ST_TXTRIG     0
`define UFMT_ST_RXTRIG     1
`define UFMT_ST_PERR       2
`define UFMT_ST_FERR       3

// FIFO geometry
`define UFMT_DEPTH         64
`define UFMT_AW            6
`define UFMT_CW            7

// Divisor reset value (arbitrary small default)
`define UFMT_DIV_RST       16'h0001

`endif

// [rtl/ufmt_fifo.v]
// Flip-flop character FIFO with fill count and synchronous clear.
// Assumes one clock; writer and reader respect full and empty.
`timescale 1ns/1ps
`include "ufmt_regs.vh"

module ufmt_fifo (
    ref_clk,
    rst_n,
    clr,
    wr_valid,
    wr_data,
    wr_ready,
    rd_valid,
    rd_ready,
    rd_data,
    count
);
    input  wire       ref_clk;
    input  wire       rst_n;
    input  wire       clr;      // Drop all contents
    input  wire       wr_valid; // Push request
    input  wire [7:0] wr_data;  // Push data
    output wire       wr_ready; // Not full
    output wire       rd_valid; // Not empty
    input  wire       rd_ready; // Pop request
    output wire [7:0] rd_data;  // Head character
    output wire [`UFMT_CW-1:0] count; // Fill count

    reg  [7:0]          mem_r [0:`UFMT_DEPTH-1]; // Storage
    reg  [`UFMT_AW-1:0] wp_r;                    // Write index
    reg  [`UFMT_AW-1:0] rp_r;                    // Read index
    reg  [`UFMT_CW-1:0] cnt_r;                   // Fill count
    wire                push;
    wire                pop;

    assign wr_ready = (cnt_r != 7'h40);
    assign rd_valid = (cnt_r != 7'h00);
    assign push     = wr_valid & wr_ready;
    assign pop      = rd_ready & rd_valid;
    assign rd_data  = mem_r[rp_r];
    assign count    = cnt_r;

    // ------------------------------------------------------------
    // Index and count update
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= 6'h00;
            rp_r  <= 6'h00;
            cnt_r <= 7'h00;
        end else if (clr) begin
            wp_r  <= 6'h00;
            rp_r  <= 6'h00;
            cnt_r <= 7'h00;
        end else begin
            if (push)
                wp_r <= wp_r + 6'h01;
            if (pop)
                rp_r <= rp_r + 6'h01;
            if (push & ~pop)
                cnt_r <= cnt_r + 7'h01;
            else if (pop & ~push)
                cnt_r <= cnt_r - 7'h01;
        end
    end

    // Storage write, no reset needed
    always @(posedge ref_clk) begin
        if (push & ~clr)
            mem_r[wp_r] <= wr_data;
    end
endmodule

// [rtl/ufmt_serial.v]
// Serial framer: one transmitter and one receiver sharing a bit tick.
// Assumes format inputs are steady while a character is in flight.
`timescale 1ns/1ps
`include "ufmt_regs.vh"

module ufmt_serial (
    ref_clk,
    rst_n,
    tick16,
    wlen,
    stop_sel,
    par_en,
    par_even,
    par_stick,
    brk,
    tx_valid,
    tx_data,
    tx_ready,
    tx_idle,
    txd,
    rxd_s,
    rx_valid,
    rx_data,
    rx_perr,
    rx_ferr
);
    input  wire       ref_clk;
    input  wire       rst_n;
    input  wire       tick16;    // 16x bit rate strobe
    input  wire [1:0] wlen;      // Word length code
    input  wire       stop_sel;  // Longer stop
    input  wire       par_en;    // Parity on
    input  wire       par_even;  // Even select
    input  wire       par_stick; // Stick parity
    input  wire       brk;       // Force space
    input  wire       tx_valid;  // Character waiting
    input  wire [7:0] tx_data;   // Character
    output wire       tx_ready;  // Take character
    output wire       tx_idle;   // Shifter empty
    output reg        txd;       // Serial out
    input  wire       rxd_s;     // Synchronised serial in
    output reg        rx_valid;  // Character received pulse
    output reg  [7:0] rx_data;   // Received character
    output reg        rx_perr;   // Parity error with it
    output reg        rx_ferr;   // Stop error with it

    localparam S_IDLE = 2'h0;
    localparam S_DATA = 2'h1;
    localparam S_PAR  = 2'h2;
    localparam S_STOP = 2'h3;

    // Parity bit for data under current format
    function par_bit;
        input [7:0] d;
        input [1:0] wl;
        reg   [7:0] m;
        begin
            m = d & (8'h1f | ({6'h00, wl} == 8'h00 ? 8'h00 :
                     wl == 2'h1 ? 8'h20 : wl == 2'h2 ? 8'h60 : 8'he0));
            if (par_stick)
                par_bit = ~par_even;
            else
                par_bit = ~(^m) ^ par_even;
        end
    endfunction

    wire [3:0] nbits  = {2'h0, wlen} + 4'h5;
    // Stop length in 16x ticks
    wire [5:0] stop_t = !stop_sel ? 6'h10 : (wlen == 2'h0 ? 6'h18 : 6'h20);

    reg  [1:0] ts_r;   // Tx state
    reg  [5:0] tt_r;   // Tx tick count
    reg  [3:0] tb_r;   // Tx bit index
    reg  [7:0] tsh_r;  // Tx shifter
    reg        tline_r;
    reg        tp_r;

    assign tx_ready = (ts_r == S_IDLE) & ~tline_r;
    assign tx_idle  = (ts_r == S_IDLE) & ~tline_r;

    // ------------------------------------------------------------
    // Transmitter, start state uses tline_r as start flag
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_r <= S_IDLE; tt_r <= 6'h00; tb_r <= 4'h0;
            tsh_r <= 8'h00; tline_r <= 1'b0; tp_r <= 1'b0;
        end else if (ts_r == S_IDLE) begin
            if (!tline_r && tx_valid) begin
                tline_r <= 1'b1; tsh_r <= tx_data; tt_r <= 6'h00;
                tp_r <= par_bit(tx_data, wlen);
            end else if (tline_r && tick16) begin
                tt_r <= tt_r + 6'h01;
                if (tt_r == 6'h0f) begin
                    ts_r <= S_DATA; tt_r <= 6'h00; tb_r <= 4'h0;
                end
            end
        end else if (tick16) begin
            tt_r <= tt_r + 6'h01;
            case (ts_r)
                S_DATA: begin
                    if (tt_r == 6'h0f) begin
                        tt_r <= 6'h00; tsh_r <= {1'b0, tsh_r[7:1]};
                        tb_r <= tb_r + 4'h1;
                        if (tb_r == nbits - 4'h1)
                            ts_r <= par_en ? S_PAR : S_STOP;
                    end
                end
                S_PAR: begin
                    if (tt_r == 6'h0f) begin
                        tt_r <= 6'h00; ts_r <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (tt_r == stop_t - 6'h01) begin
                        ts_r <= S_IDLE; tline_r <= 1'b0; tt_r <= 6'h00;
                    end
                end
                default: ts_r <= S_IDLE;
            endcase
        end
    end

    // Line level; break overrides only the pin
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            txd <= 1'b1;
        else if (brk)
            txd <= 1'b0;
        else if (ts_r == S_IDLE)
            txd <= ~tline_r;
        else if (ts_r == S_DATA)
            txd <= tsh_r[0];
        else if (ts_r == S_PAR)
            txd <= tp_r;
        else
            txd <= 1'b1;
    end

    reg  [1:0] rs_r;   // Rx state
    reg  [4:0] rt_r;   // Rx tick count
    reg  [3:0] rb_r;   // Rx bit index
    reg  [7:0] rsh_r;  // Rx shifter
    reg        rpe_r;  // Parity mismatch seen

    // ------------------------------------------------------------
    // Receiver, mid-bit sampling
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_r <= S_IDLE; rt_r <= 5'h00; rb_r <= 4'h0; rsh_r <= 8'h00;
            rpe_r <= 1'b0; rx_valid <= 1'b0; rx_data <= 8'h00;
            rx_perr <= 1'b0; rx_ferr <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (tick16) begin
                rt_r <= rt_r + 5'h01;
                case (rs_r)
                    S_IDLE: begin
                        if (rxd_s)
                            rt_r <= 5'h00;
                        else if (rt_r == 5'h07) begin
                            rs_r <= S_DATA; rt_r <= 5'h00; rb_r <= 4'h0;
                            rpe_r <= 1'b0;
                        end
                    end
                    S_DATA: begin
                        if (rt_r == 5'h0f) begin
                            rt_r <= 5'h00;
                            rsh_r <= {rxd_s, rsh_r[7:1]};
                            rb_r <= rb_r + 4'h1;
                            if (rb_r == nbits - 4'h1)
                                rs_r <= par_en ? S_PAR : S_STOP;
                        end
                    end
                    S_PAR: begin
                        if (rt_r == 5'h0f) begin
                            rt_r <= 5'h00; rs_r <= S_STOP;
                            // Check against expected bit
                            rpe_r <= rxd_s ^ par_bit(rsh_r >> (4'h8 - nbits), wlen);
                        end
                    end
                    S_STOP: begin
                        if (rt_r == 5'h0f) begin
                            rs_r <= S_IDLE; rt_r <= 5'h00; rx_valid <= 1'b1;
                            rx_data <= rsh_r >> (4'h8 - nbits);
                            rx_perr <= rpe_r; rx_ferr <= ~rxd_s;
                        end
                    end
                    default: rs_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// [rtl/ufmt_top.v]
// Top of the UART trigger and line format block: registers, FIFOs, framer.
// Assumes a same-clock register master; serial input is asynchronous.
//
// Overview of operation
// - Tx interrupt when fill below trigger level
// - Rx interrupt when fill equals trigger level
// - Tx trigger writable only when feature unlocked
// - Reset clears FIFO control register
// - FIFO control writes need enable bit set
// - Low two bits choose five to eight bits
// - Stop select: one, one-and-half or two
// - Parity bit after data, even or odd
// - Stick parity forces bit opposite even-select
// - Break holds output low, logic continues
// - Access bit switches to divisor and feature
// - Reset clears line format register
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "ufmt_regs.vh"

module ufmt_top (
    ref_clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    irq,
    rxd,
    txd
);
    input  wire       ref_clk;   // 20 MHz clock
    input  wire       rst_n;     // Async reset
    input  wire [2:0] reg_addr;  // Register offset
    input  wire [7:0] reg_wdata; // Write data
    input  wire       reg_wr;    // Write strobe
    input  wire       reg_rd;    // Read strobe
    output reg  [7:0] reg_rdata; // Read data, cycle after strobe
    output wire       irq;       // Level interrupt
    input  wire       rxd;       // Serial in pin
    output wire       txd;       // Serial out pin

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  fifo_control_r;        // FIFO control
    reg  [7:0]  line_format_control_r; // Line format control
    reg  [7:0]  enhanced_feature_reg_r;// Feature unlock
    reg  [7:0]  interrupt_enable_reg_r;// Kept for software
    reg  [15:0] baud_div_r;            // Divisor latches
    reg  [3:0]  stat_r;                // Sticky events
    reg  [3:0]  mask_r;                // Interrupt mask
    reg  [15:0] bcnt_r;                // Baud counter
    reg         tick_r;                // 16x strobe
    reg  [1:0]  rx_sync_r;             // Pin synchroniser
    reg  [7:0]  fc_nxt;                // Next FIFO control
    reg  [3:0]  stat_nxt;              // Next status
    reg  [7:0]  rd_nxt;                // Next read data

    wire        dlab  = line_format_control_r[`UFMT_LC_DLAB];
    wire        wr_fc = reg_wr & (reg_addr == `UFMT_OFS_FIFO) & ~dlab;
    wire        wr_ef = reg_wr & (reg_addr == `UFMT_OFS_EFR) & dlab;
    wire        wr_th = reg_wr & (reg_addr == `UFMT_OFS_DATA) & ~dlab;
    wire        rd_rb = reg_rd & (reg_addr == `UFMT_OFS_DATA) & ~dlab;

    wire [`UFMT_CW-1:0] tx_cnt;
    wire [`UFMT_CW-1:0] rx_cnt;
    wire        tx_wr_ready;
    wire        tx_q_valid;
    wire [7:0]  tx_q_data;
    wire        tx_idle;
    wire        rx_q_valid;
    wire [7:0]  rx_q_data;
    wire        rx_wr_ready;
    wire        rx_valid;
    wire [7:0]  rx_data;
    wire        rx_perr;
    wire        rx_ferr;
    wire        tx_take;

    // Trigger level decode
    function [6:0] tx_level;
        input [1:0] code;
        begin
            case (code)
                2'h0:    tx_level = 7'h08;
                2'h1:    tx_level = 7'h10;
                2'h2:    tx_level = 7'h20;
                default: tx_level = 7'h38;
            endcase
        end
    endfunction

    function [6:0] rx_level;
        input [1:0] code;
        begin
            case (code)
                2'h0:    rx_level = 7'h08;
                2'h1:    rx_level = 7'h10;
                2'h2:    rx_level = 7'h38;
                default: rx_level = 7'h3c;
            endcase
        end
    endfunction

    wire fifo_on = fifo_control_r[`UFMT_FC_EN];
    wire tx_trig = fifo_on &
        (tx_cnt < tx_level(fifo_control_r[`UFMT_FC_TXT_HI:`UFMT_FC_TXT_LO]));
    wire rx_trig = fifo_on &
        (rx_cnt == rx_level(fifo_control_r[`UFMT_FC_RXT_HI:`UFMT_FC_RXT_LO]));
    reg  tx_trig_d_r;
    reg  rx_trig_d_r;

    // Clear pulses, also on leaving or entering FIFO mode
    wire mode_chg = wr_fc & (reg_wdata[`UFMT_FC_EN] != fifo_on);
    wire tx_clr   = (wr_fc & reg_wdata[`UFMT_FC_EN] & reg_wdata[`UFMT_FC_TXCLR]) | mode_chg;
    wire rx_clr   = (wr_fc & reg_wdata[`UFMT_FC_EN] & reg_wdata[`UFMT_FC_RXCLR]) | mode_chg;

    // FIFO control next value; clear bits are self-clearing
    always @* begin
        fc_nxt = fifo_control_r;
        if (wr_fc) begin
            if (reg_wdata[`UFMT_FC_EN]) begin
                fc_nxt[7:6] = reg_wdata[7:6];
                fc_nxt[3]   = reg_wdata[3];
                fc_nxt[0]   = 1'b1;
                if (enhanced_feature_reg_r[`UFMT_EF_UNLOCK])
                    fc_nxt[5:4] = reg_wdata[5:4];
            end else begin
                fc_nxt[0] = 1'b0;
            end
        end
        fc_nxt[2:1] = 2'h0;
    end

    // Status next value; a new event beats the read clear
    always @* begin
        stat_nxt = stat_r;
        if (reg_rd && reg_addr == `UFMT_OFS_STATUS)
            stat_nxt = 4'h0;
        if (tx_trig & ~tx_trig_d_r)
            stat_nxt[`UFMT_ST_TXTRIG] = 1'b1;
        if (rx_trig & ~rx_trig_d_r)
            stat_nxt[`UFMT_ST_RXTRIG] = 1'b1;
        if (rx_valid & rx_perr)
            stat_nxt[`UFMT_ST_PERR] = 1'b1;
        if (rx_valid & rx_ferr)
            stat_nxt[`UFMT_ST_FERR] = 1'b1;
    end

    // Read mux
    always @* begin
        rd_nxt = 8'h00;
        case (reg_addr)
            `UFMT_OFS_DATA:   rd_nxt = dlab ? baud_div_r[7:0] : rx_q_data;
            `UFMT_OFS_IEN:    rd_nxt = dlab ? baud_div_r[15:8] : interrupt_enable_reg_r;
            `UFMT_OFS_FIFO:   rd_nxt = dlab ? enhanced_feature_reg_r : 8'h00;
            `UFMT_OFS_LINE:   rd_nxt = line_format_control_r;
            `UFMT_OFS_STATUS: rd_nxt = {2'h0, tx_idle, tx_idle & ~tx_q_valid, stat_r};
            `UFMT_OFS_MASK:   rd_nxt = {4'h0, mask_r};
            default:          rd_nxt = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Register writes and read data
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_control_r         <= `UFMT_FIFO_RST;
            line_format_control_r  <= `UFMT_LINE_RST;
            enhanced_feature_reg_r <= 8'h00;
            interrupt_enable_reg_r <= 8'h00;
            baud_div_r             <= `UFMT_DIV_RST;
            stat_r                 <= 4'h0;
            mask_r                 <= 4'h0;
            reg_rdata              <= 8'h00;
            tx_trig_d_r            <= 1'b0;
            rx_trig_d_r            <= 1'b0;
        end else begin
            fifo_control_r <= fc_nxt;
            stat_r         <= stat_nxt;
            tx_trig_d_r    <= tx_trig;
            rx_trig_d_r    <= rx_trig;
            reg_rdata      <= reg_rd ? rd_nxt : 8'h00;
            if (reg_wr && reg_addr == `UFMT_OFS_LINE)
                line_format_control_r <= reg_wdata;
            if (wr_ef)
                enhanced_feature_reg_r <= reg_wdata;
            if (reg_wr && reg_addr == `UFMT_OFS_DATA && dlab)
                baud_div_r[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == `UFMT_OFS_IEN && dlab)
                baud_div_r[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == `UFMT_OFS_IEN && !dlab)
                interrupt_enable_reg_r <= reg_wdata;
            if (reg_wr && reg_addr == `UFMT_OFS_MASK)
                mask_r <= reg_wdata[3:0];
        end
    end

    assign irq = |(stat_r & mask_r);

    // ------------------------------------------------------------
    // Baud tick and pin synchroniser
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r    <= 16'h0000;
            tick_r    <= 1'b0;
            rx_sync_r <= 2'h3;
        end else begin
            rx_sync_r <= {rx_sync_r[0], rxd};
            tick_r    <= 1'b0;
            if (bcnt_r >= baud_div_r - 16'h0001) begin
                bcnt_r <= 16'h0000;
                tick_r <= 1'b1;
            end else begin
                bcnt_r <= bcnt_r + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // FIFOs and framer
    // ------------------------------------------------------------
    ufmt_fifo u_txq (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clr      (tx_clr),
        .wr_valid (wr_th),
        .wr_data  (reg_wdata),
        .wr_ready (tx_wr_ready),
        .rd_valid (tx_q_valid),
        .rd_ready (tx_take),
        .rd_data  (tx_q_data),
        .count    (tx_cnt)
    );

    ufmt_fifo u_rxq (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clr      (rx_clr),
        .wr_valid (rx_valid),
        .wr_data  (rx_data),
        .wr_ready (rx_wr_ready),
        .rd_valid (rx_q_valid),
        .rd_ready (rd_rb),
        .rd_data  (rx_q_data),
        .count    (rx_cnt)
    );

    // Framer starts a character when idle and a byte waits
    assign tx_take = tx_idle & tx_q_valid;

    ufmt_serial u_ser (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .tick16    (tick_r),
        .wlen      (line_format_control_r[1:0]),
        .stop_sel  (line_format_control_r[`UFMT_LC_STOP]),
        .par_en    (line_format_control_r[`UFMT_LC_PEN]),
        .par_even  (line_format_control_r[`UFMT_LC_EVEN]),
        .par_stick (line_format_control_r[`UFMT_LC_STICK]),
        .brk       (line_format_control_r[`UFMT_LC_BRK]),
        .tx_valid  (tx_take),
        .tx_data   (tx_q_data),
        .tx_ready  (),
        .tx_idle   (tx_idle),
        .txd       (txd),
        .rxd_s     (rx_sync_r[1]),
        .rx_valid  (rx_valid),
        .rx_data   (rx_data),
        .rx_perr   (rx_perr),
        .rx_ferr   (rx_ferr)
    );
endmodule

// [tb/ufmt_assertions.sv]
// Checker for the trigger and line format block, bound to ufmt_top.
// Assumes the plain register port and one clock domain.
`timescale 1ns/1ps
module ufmt_assertions (
    ref_clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    irq,
    rxd,
    txd
);
    input wire       ref_clk;
    input wire       rst_n;
    input wire [2:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire       reg_wr;
    input wire       reg_rd;
    input wire [7:0] reg_rdata;
    input wire       irq;
    input wire       rxd;
    input wire       txd;
    reg [7:0] line_r; // Shadow line format
    reg [7:0] ien_r;  // Shadow interrupt enable
    reg [7:0] dlh_r;  // Shadow divisor high
    reg [7:0] mask_r; // Shadow mask
    // Shadows follow host writes
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_r <= 8'h00;
            ien_r  <= 8'h00;
            dlh_r  <= 8'h00;
            mask_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 3'h3) line_r <= reg_wdata;
            if (reg_addr == 3'h1 && line_r[7]) dlh_r <= reg_wdata;
            if (reg_addr == 3'h1 && !line_r[7]) ien_r <= reg_wdata;
            if (reg_addr == 3'h5) mask_r <= reg_wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_line_readback: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata == line_r)
        else $error("line format readback wrong");
    a_ien_route: assert property (reg_rd && reg_addr == 3'h1 && !line_r[7] |=> reg_rdata == ien_r)
        else $error("enable register routing wrong");
    a_divisor_route: assert property (reg_rd && reg_addr == 3'h1 && line_r[7] |=> reg_rdata == dlh_r)
        else $error("divisor routing wrong");
    a_fifo_write_only: assert property (reg_rd && reg_addr == 3'h2 && !line_r[7] |=> reg_rdata == 8'h00)
        else $error("fifo control read not zero");
    a_break_low: assert property (line_r[6] && $past(line_r[6], 3) |-> !txd)
        else $error("break does not hold line low");
    a_irq_masked: assert property (mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !irq)
        else $error("interrupt while fully masked");
    a_txd_rst_high: assert property ($rose(rst_n) |-> txd)
        else $error("line not marking after reset");
endmodule

bind ufmt_top ufmt_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .rxd(rxd), .txd(txd));

// [tb/ufmt_line_partner.sv]
// Remote serial terminal: sends 8N1 characters on the receive line.
// Assumes divisor 1, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module ufmt_line_partner (
    ref_clk,
    rxd
);
    input  wire ref_clk; // Shared clock
    output reg  rxd;     // Line into the block
    initial rxd = 1'b1;  // Marking while idle
    // One character, low start, lsb first, one stop
    task send(input [7:0] d);
        integer i;
        begin
            @(posedge ref_clk) rxd <= 1'b0;
            repeat (16) @(posedge ref_clk);
            for (i = 0; i < 8; i = i + 1) begin
                rxd <= d[i];
                repeat (16) @(posedge ref_clk);
            end
            rxd <= 1'b1;
            repeat (32) @(posedge ref_clk);
        end
    endtask
endmodule

// [tb/test_ufmt_top.sv]
// Self-checking bench for ufmt_top with a serial terminal model.
// Assumes reset divisor 1 and registers at offsets 0 to 5.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin \
    error_cnt = error_cnt + 1; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module test_ufmt_top;
    reg        ref_clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    reg  [2:0] reg_addr = 3'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg  [7:0] rv;
    wire [7:0] reg_rdata;
    wire       irq;
    wire       rxd;
    wire       txd;
    integer    error_cnt = 0;
    integer    num_checks = 0;
    integer    cyc = 0;
    integer    i;
    always #25 ref_clk = ~ref_clk;
    ufmt_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .rxd(rxd), .txd(txd));
    ufmt_line_partner line (.ref_clk(ref_clk), .rxd(rxd));
    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    task finish_test;
        begin
            $display("checks %0d errors %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [2:0] a);
        begin
            @(posedge ref_clk);
            reg_addr <= a; reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            #1 rv = reg_rdata;
        end
    endtask
    task t_format;
        begin
            rd(3'h3); `CHK(rv, 8'h00)
            for (i = 0; i < 4; i = i + 1) begin
                wr(3'h3, i * 5); rd(3'h3); `CHK(rv, i * 5)
            end
            wr(3'h3, 8'h80); wr(3'h1, 8'h00); wr(3'h0, 8'h01);
            rd(3'h1); `CHK(rv, 8'h00)
            wr(3'h3, 8'h00); wr(3'h1, 8'h05);
            rd(3'h1); `CHK(rv, 8'h05)
            wr(3'h3, 8'h40); tick(4); `CHK(txd, 1'b0)
            wr(3'h3, 8'h03); tick(4); `CHK(txd, 1'b1)
            $display("format test done");
        end
    endtask
    task t_irq;
        begin
            wr(3'h2, 8'h01); wr(3'h5, 8'h01); tick(1);
            `CHK(irq, 1'b1)
            rd(3'h4); wr(3'h5, 8'h02);
            for (i = 0; i < 7; i = i + 1) line.send(i);
            tick(20); `CHK(irq, 1'b0)
            line.send(8'h07); tick(20); `CHK(irq, 1'b1)
            rd(3'h4); `CHK(rv[1], 1'b1)
            tick(1); `CHK(irq, 1'b0)
            rd(3'h0); `CHK(rv, 8'h00)
            rd(3'h0); `CHK(rv, 8'h01)
            $display("trigger test done");
        end
    endtask
    task t_frame(input [7:0] lc, input par);
        begin
            wr(3'h3, lc); wr(3'h0, 8'h01);
            for (i = 0; i < 200 && txd; i = i + 1) tick(1);
            tick(8);
            for (i = 0; i < 8; i = i + 1) begin
                tick(16); `CHK(txd, i == 0)
            end
            tick(16); `CHK(txd, par)
            tick(16); `CHK(txd, 1'b1)
            $display("frame test done");
        end
    endtask
    // Host break sequence: zero byte, break, wait for idle, release
    task t_break;
        begin
            wr(3'h3, 8'h03); wr(3'h0, 8'h00); wr(3'h3, 8'h43);
            rv = 8'h00;
            for (i = 0; i < 400 && !rv[4]; i = i + 1) rd(3'h4);
            `CHK(rv[4], 1'b1)
            `CHK(txd, 1'b0)
            wr(3'h3, 8'h03); tick(2); `CHK(txd, 1'b1)
            $display("break test done");
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_format;
        t_irq;
        t_frame(8'h0b, 1'b0);
        t_frame(8'h1b, 1'b1);
        t_frame(8'h3b, 1'b0);
        t_break;
        finish_test;
    end
endmodule
